/* File: sai_host_model.sv */
// Purpose: Host that sources bit clock, word select and serial data.
// Assumes: Frame settings are read at every bit while run is high; run is checked at each frame start.
// Notes:   The bit clock stands low while run is low.
`timescale 1ns/10ps
module sai_host_model
	import sai_pkg::*;
(
	input  wire logic        run,
	input  wire sai_fmt_type fmt,
	input  wire logic        ofs,
	input  wire logic [9:0]  bpf,
	input  wire logic [5:0]  wlen,
	input  wire logic [31:0] hl,
	input  wire logic [31:0] hr,
	output logic             clk_bit,
	output logic             ws,
	output logic             sd
);
	// ----------------------------------------------------------------
	// Frame builder
	// ----------------------------------------------------------------
	logic idle;
	int   n;
	function automatic logic [1:0] bit_at(input int n);
		int   half, wl, m, ch, i;
		logic w;
		half = bpf / 2;
		wl = wlen;
		ch = n / half;
		i = n % half;
		w = (n < half);
		case (fmt)
			SAI_FMT_I2S: begin
				m = (n + bpf - 1) % bpf;
				ch = m / half;
				i = m % half;
				w = (n >= half);
			end
			SAI_FMT_RIGHT_JUSTIFIED_FORMAT: i = n % half - (half - wl);
			SAI_FMT_TDM: begin
				m = n - int'(ofs);
				ch = m / wl;
				i = m % wl;
				w = (n == 0);
			end
			default: ;
		endcase
		return {w, (i >= 0 && i < wl && ch < 2) ? (ch != 0 ? hr[31 - i] : hl[31 - i]) : 1'b0};
	endfunction : bit_at
	initial begin
		clk_bit = 1'b0;
		ws = 1'b0;
		sd = 1'b0;
		idle = 1'b1;
		#17;
		forever begin
			if (run !== 1'b1) begin
				clk_bit = 1'b0;
				if (!idle) begin
					ws = ~ws;
					sd = ~sd;
				end
				idle = 1'b1;
				#62.5;
			end else begin
				idle = 1'b0;
				for (n = 0; n < bpf; n++) begin
					clk_bit = 1'b0;
					{ws, sd} = bit_at(n);
					#62.5;
					clk_bit = 1'b1;
					#62.5;
				end
			end
		end
	end
endmodule : sai_host_model

/* File: sai_map.svh */
// Functional notes
// - Internal clocks derived from bit clock only; here registers and supervision run on clk_sys.
// - Detect sample rate, configure processing clocks.
// - Clock halt: sleep processing, outputs high-impedance.
// - Auto-resume after halt, configuration kept.
// - Clock error flagged in fault status register.
// - Two-channel formats: 32/64 bit clocks per frame.
// - TDM ratios 128/256/512 limited by rate.
// - Format chosen by control bits 5:4.
// - Two's complement, MSB first, up to 32 bits.
// - Word length from bit 7 plus length register.
// - Reset default: I2S format, 24-bit words.
// - TDM frame starts at frame sync rising edge.
// - I2S: left while word select low.
// - Right-justified: left while word select high.
// - Bit clock is the only shift clock.
// - TDM first slot at offset zero or one.
// - Word select is word clock or frame sync.
// - Sample data and word select on rising edge.
// - Port is clock target; host sources clocks.
//
// Purpose: Register map, field positions, reset values and timing counts.
// Assumes: Included by its bare name.
// Notes:   Definitions only.
`ifndef SAI_MAP_SVH
`define SAI_MAP_SVH

// ----------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------
`define SAI_ADDR_FMT_CTL      8'h33
`define SAI_ADDR_WLEN_CTL     8'h34
`define SAI_ADDR_CLK_FAULT    8'h71
`define SAI_FMT_CTL_RESET     8'h00
`define SAI_WLEN_CTL_RESET    8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SAI_FMT_LSB           4
`define SAI_FMT_MSB           5
`define SAI_TDM_OFS_BIT       6
`define SAI_WLEN_HI_BIT       7
`define SAI_STAT_ERR_BIT      0
`define SAI_STAT_HALT_BIT     1
`define SAI_STAT_RATIO_BIT    2
`define SAI_STAT_RATE_BIT     3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SAI_CLK_KHZ           25000
`define SAI_HALT_TIMEOUT_US   40
`define SAI_HALT_CYCLES       ((`SAI_HALT_TIMEOUT_US * `SAI_CLK_KHZ) / 1000)
`define SAI_RECOVER_FRAMES    2
`define SAI_MIN_RATE_KHZ      28
`define SAI_BND_32_48_KHZ     38
`define SAI_BND_48_96_KHZ     68
`define SAI_BND_96_192_KHZ    136
`define SAI_MAX_RATE_KHZ      200
`define SAI_FULL_WORD         32

`endif

/* File: sai_pkg.sv */
// Purpose: Types shared by the serial audio input port.
// Assumes: Nothing.
// Notes:   Constants live in sai_map.svh.
package sai_pkg;

	typedef enum logic [1:0] {
		SAI_FMT_I2S                    = 2'b00,
		SAI_FMT_LEFT_JUSTIFIED_FORMAT  = 2'b01,
		SAI_FMT_RIGHT_JUSTIFIED_FORMAT = 2'b10,
		SAI_FMT_TDM                    = 2'b11
	} sai_fmt_type;

	typedef enum logic [2:0] {
		SAI_RATE_NONE = 3'b000,
		SAI_RATE_32K  = 3'b001,
		SAI_RATE_48K  = 3'b010,
		SAI_RATE_96K  = 3'b011,
		SAI_RATE_192K = 3'b100
	} sai_rate_type;

	typedef enum logic [0:0] {
		SAI_PLAY  = 1'b0,
		SAI_SLEEP = 1'b1
	} sai_state_type;

	typedef struct packed {
		sai_fmt_type fmt;
		logic        tdm_offset;
		logic [8:0]  word_len;
	} sai_cfg_type;

	typedef struct packed {
		logic bit_tgl;
		logic frame_tgl;
		logic pair_tgl;
	} sai_event_type;

endpackage : sai_pkg

/* File: sai_port.sv */
// Purpose: Target-mode serial audio input port with clock supervision.
// Assumes: Host drives bit clock, word select and data; registers reached
//          through a simple strobe port.
// Notes:   Link logic runs on clk_bit; supervision runs on clk_sys.
`timescale 1ns/10ps
`include "sai_map.svh"
module sai_port
	import sai_pkg::*;
#(
	parameter int HALT_CYCLES    = `SAI_HALT_CYCLES,
	parameter int RECOVER_FRAMES = `SAI_RECOVER_FRAMES
)(
	input  wire logic          clk_sys,
	input  wire logic          rst_b,
	input  wire logic          clk_bit,
	input  wire logic          word_select_frame_sync,
	input  wire logic          serial_data_input,
	input  wire logic [7:0]    reg_addr,
	input  wire logic [7:0]    reg_wdata,
	input  wire logic          reg_write,
	input  wire logic          reg_read,
	output logic      [7:0]    reg_rdata,
	output logic      [31:0]   sample_left,
	output logic      [31:0]   sample_right,
	output logic               sample_valid,
	output logic               out_hiz,
	output logic               dsp_sleep,
	output sai_rate_type       proc_clock_rate
);
	generate
		if (HALT_CYCLES < 2 || HALT_CYCLES > 65535) begin : g_bad_halt
			$error("sai_port: HALT_CYCLES out of range.");
		end
		if (RECOVER_FRAMES < 1 || RECOVER_FRAMES > 15) begin : g_bad_rec
			$error("sai_port: RECOVER_FRAMES out of range.");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Registers (system clock)
	// ----------------------------------------------------------------
	logic [7:0]  fmt_ctl;
	logic [7:0]  wlen_ctl;
	logic [7:0]  fault_status;
	sai_cfg_type cfg_sys;

	wire wr_fmt  = reg_write & (reg_addr == `SAI_ADDR_FMT_CTL);
	wire wr_wlen = reg_write & (reg_addr == `SAI_ADDR_WLEN_CTL);
	wire [7:0] rd_mux = (reg_addr == `SAI_ADDR_FMT_CTL)   ? fmt_ctl :
	                    (reg_addr == `SAI_ADDR_WLEN_CTL)  ? wlen_ctl :
	                    (reg_addr == `SAI_ADDR_CLK_FAULT) ? fault_status : 8'h00;

	// Configuration is never touched by halts, so playback resumes unchanged.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			fmt_ctl  <= `SAI_FMT_CTL_RESET;
			wlen_ctl <= `SAI_WLEN_CTL_RESET;
		end else begin
			if (wr_fmt)
				fmt_ctl <= reg_wdata;
			if (wr_wlen)
				wlen_ctl <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
			cfg_sys   <= '0;
		end else begin
			if (reg_read)
				reg_rdata <= rd_mux;
			cfg_sys.fmt        <= sai_fmt_type'(fmt_ctl[`SAI_FMT_MSB:`SAI_FMT_LSB]);
			cfg_sys.tdm_offset <= fmt_ctl[`SAI_TDM_OFS_BIT];
			cfg_sys.word_len   <= {fmt_ctl[`SAI_WLEN_HI_BIT], wlen_ctl};
		end
	end

	// ----------------------------------------------------------------
	// Link logic (bit clock)
	// ----------------------------------------------------------------
	// Configuration is quasi-static; change it only while clocks are halted.
	sai_cfg_type   cfg_link;
	sai_event_type ev_link;
	logic          ws_d1;
	logic          eff_prev;
	logic [31:0]   shreg;
	logic [9:0]    bit_idx;
	logic [9:0]    frame_bits;
	logic [9:0]    ratio_hold;
	logic [3:0]    slot_cnt;
	logic [31:0]   left_hold;
	logic [31:0]   right_hold;

	sai_sync #(
		.WIDTH ($bits(sai_cfg_type))
	) u_cfg_sync (
		.clk   (clk_bit),
		.rst_b (rst_b),
		.din   (cfg_sys),
		.dout  (cfg_link)
	);

	wire is_tdm   = (cfg_link.fmt == SAI_FMT_TDM);
	wire is_i2s   = (cfg_link.fmt == SAI_FMT_I2S);
	wire right_justified_format = (cfg_link.fmt == SAI_FMT_RIGHT_JUSTIFIED_FORMAT);
	// I2S delayed one bit lines up with left-justified; so does TDM offset one.
	wire use_dly  = is_i2s | (is_tdm & cfg_link.tdm_offset);
	wire eff_raw  = use_dly ? ws_d1 : word_select_frame_sync;
	// Internal word select is high for left: I2S inverts, the justified formats do not.
	wire eff_ws   = is_i2s ? ~eff_raw : eff_raw;
	wire ws_edge  = eff_ws ^ eff_prev;
	wire fr_start = eff_ws & ~eff_prev;
	wire [8:0] wl_raw = cfg_link.word_len;
	wire [8:0] wl_c   = ((wl_raw == 9'h000) || (wl_raw > 9'd`SAI_FULL_WORD)) ? 9'd`SAI_FULL_WORD : wl_raw;
	wire [4:0] align  = 5'(6'd`SAI_FULL_WORD - wl_c[5:0]);
	wire slot_done    = is_tdm & (bit_idx == {1'b0, wl_c});
	wire word_done    = is_tdm ? slot_done : ws_edge;
	wire restart      = word_done | (is_tdm & fr_start);
	// Right-justified shifts always and keeps the last bits before the edge.
	wire shift_en     = right_justified_format | (bit_idx < {1'b0, wl_c});
	wire [31:0] aligned = shreg << align;
	wire to_left      = is_tdm ? (slot_cnt == 4'h0) : eff_prev;
	wire cap_en       = word_done & (!is_tdm | (slot_cnt < 4'h2));
	wire pair_end     = cap_en & !to_left;

	// Sampling on the rising bit clock edge.
	always_ff @(posedge clk_bit or negedge rst_b) begin
		if (!rst_b) begin
			ws_d1    <= 1'b0;
			eff_prev <= 1'b0;
			shreg    <= 32'h0000_0000;
			bit_idx  <= 10'h000;
		end else begin
			ws_d1    <= word_select_frame_sync;
			eff_prev <= eff_ws;
			if (restart) begin
				shreg   <= {31'h0000_0000, serial_data_input};
				bit_idx <= 10'h001;
			end else if (shift_en) begin
				shreg   <= {shreg[30:0], serial_data_input};
				bit_idx <= bit_idx + 10'h001;
			end
		end
	end

	always_ff @(posedge clk_bit or negedge rst_b) begin
		if (!rst_b) begin
			slot_cnt <= 4'h0;
		end else if (is_tdm & fr_start) begin
			slot_cnt <= 4'h0;
		end else if (slot_done && slot_cnt != 4'hf) begin
			slot_cnt <= slot_cnt + 4'h1;
		end
	end

	always_ff @(posedge clk_bit or negedge rst_b) begin
		if (!rst_b) begin
			left_hold  <= 32'h0000_0000;
			right_hold <= 32'h0000_0000;
		end else if (cap_en) begin
			if (to_left)
				left_hold <= aligned;
			else
				right_hold <= aligned;
		end
	end

	// Bits per frame feed the ratio check on the system side.
	always_ff @(posedge clk_bit or negedge rst_b) begin
		if (!rst_b) begin
			frame_bits <= 10'h000;
			ratio_hold <= 10'h000;
		end else if (fr_start) begin
			frame_bits <= 10'h001;
			ratio_hold <= frame_bits;
		end else if (frame_bits != 10'h3ff) begin
			frame_bits <= frame_bits + 10'h001;
		end
	end

	always_ff @(posedge clk_bit or negedge rst_b) begin
		if (!rst_b) begin
			ev_link <= '0;
		end else begin
			ev_link.bit_tgl <= ~ev_link.bit_tgl;
			if (fr_start)
				ev_link.frame_tgl <= ~ev_link.frame_tgl;
			if (pair_end)
				ev_link.pair_tgl <= ~ev_link.pair_tgl;
		end
	end

	// ----------------------------------------------------------------
	// Clock supervision (system clock)
	// ----------------------------------------------------------------
	// Bit activity is a toggle; bit clocks above clk_sys alias.
	sai_event_type ev_sync;
	sai_event_type ev_prev;
	sai_state_type state;
	sai_state_type next_state;
	sai_rate_type  rate_meas;
	logic [15:0]   bit_idle;
	logic [15:0]   ws_idle;
	logic [11:0]   per_cnt;
	logic [3:0]    good_frames;
	logic [9:0]    ratio_sys;
	logic          ratio_err;
	logic          rate_err;

	sai_sync #(
		.WIDTH ($bits(sai_event_type))
	) u_ev_sync (
		.clk   (clk_sys),
		.rst_b (rst_b),
		.din   (ev_link),
		.dout  (ev_sync)
	);

	wire bit_ev   = ev_sync.bit_tgl ^ ev_prev.bit_tgl;
	wire frame_ev = ev_sync.frame_tgl ^ ev_prev.frame_tgl;
	wire pair_ev  = ev_sync.pair_tgl ^ ev_prev.pair_tgl;
	wire halted   = (bit_idle >= 16'(HALT_CYCLES)) | (ws_idle >= 16'(HALT_CYCLES));

	// Frame period in system cycles picks the rate band.
	wire per_slow = per_cnt > 12'(`SAI_CLK_KHZ / `SAI_MIN_RATE_KHZ);
	wire per_fast = per_cnt < 12'(`SAI_CLK_KHZ / `SAI_MAX_RATE_KHZ);
	wire [2:0] rate_code = (per_slow | per_fast) ? SAI_RATE_NONE :
	                       (per_cnt > 12'(`SAI_CLK_KHZ / `SAI_BND_32_48_KHZ))  ? SAI_RATE_32K :
	                       (per_cnt > 12'(`SAI_CLK_KHZ / `SAI_BND_48_96_KHZ))  ? SAI_RATE_48K :
	                       (per_cnt > 12'(`SAI_CLK_KHZ / `SAI_BND_96_192_KHZ)) ? SAI_RATE_96K : SAI_RATE_192K;
	wire sai_rate_type rate_new = sai_rate_type'(rate_code);

	wire is_tdm_sys = (cfg_sys.fmt == SAI_FMT_TDM);
	wire r32  = (ratio_sys == 10'd32);
	wire r64  = (ratio_sys == 10'd64);
	wire r128 = (ratio_sys == 10'd128);
	wire r256 = (ratio_sys == 10'd256);
	wire r512 = (ratio_sys == 10'd512);
	wire tdm_ok = (rate_new == SAI_RATE_32K) ? r128 :
	              (rate_new == SAI_RATE_48K) ? (r128 | r256 | r512) :
	              (rate_new == SAI_RATE_96K) ? (r128 | r256) : r128;
	wire ratio_ok = is_tdm_sys ? tdm_ok : (r32 | r64);
	wire frame_good = (rate_new != SAI_RATE_NONE) & ratio_ok & !halted;
	wire clock_err  = halted | ratio_err | rate_err;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ev_prev   <= '0;
			ratio_sys <= 10'h000;
		end else begin
			ev_prev   <= ev_sync;
			// Link holds this value for a whole frame after the toggle.
			if (frame_ev)
				ratio_sys <= ratio_hold;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			bit_idle <= 16'h0000;
			ws_idle  <= 16'h0000;
		end else begin
			if (bit_ev)
				bit_idle <= 16'h0000;
			else if (bit_idle != 16'hffff)
				bit_idle <= bit_idle + 16'h0001;
			if (frame_ev)
				ws_idle <= 16'h0000;
			else if (ws_idle != 16'hffff)
				ws_idle <= ws_idle + 16'h0001;
		end
	end

	// Ratio is judged one frame late, when it has arrived; rate is judged on the frame just ended.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			per_cnt   <= 12'h000;
			rate_meas <= SAI_RATE_NONE;
			ratio_err <= 1'b0;
			rate_err  <= 1'b0;
		end else if (halted) begin
			per_cnt   <= 12'h000;
			rate_meas <= SAI_RATE_NONE;
			rate_err  <= 1'b0;
		end else if (frame_ev) begin
			per_cnt   <= 12'h001;
			rate_meas <= rate_new;
			ratio_err <= !ratio_ok;
			rate_err  <= (rate_new == SAI_RATE_NONE);
		end else if (per_cnt != 12'hfff) begin
			per_cnt <= per_cnt + 12'h001;
		end
	end

	always_comb begin
		next_state = state;
		unique case (state)
			SAI_PLAY: begin
				if (clock_err)
					next_state = SAI_SLEEP;
			end
			SAI_SLEEP: begin
				if (frame_ev && frame_good && good_frames >= 4'(RECOVER_FRAMES))
					next_state = SAI_PLAY;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state       <= SAI_SLEEP;
			good_frames <= 4'h0;
		end else begin
			state <= next_state;
			if (state == SAI_PLAY || halted || (frame_ev && !frame_good))
				good_frames <= 4'h0;
			else if (frame_ev && good_frames != 4'hf)
				good_frames <= good_frames + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			fault_status    <= 8'h00;
			out_hiz         <= 1'b1;
			dsp_sleep       <= 1'b1;
			proc_clock_rate <= SAI_RATE_NONE;
			sample_left     <= 32'h0000_0000;
			sample_right    <= 32'h0000_0000;
			sample_valid    <= 1'b0;
		end else begin
			fault_status <= {1'b0, rate_meas, rate_err, ratio_err, halted, clock_err};
			out_hiz      <= (next_state == SAI_SLEEP);
			dsp_sleep    <= (next_state == SAI_SLEEP);
			proc_clock_rate <= (next_state == SAI_PLAY) ? rate_meas : SAI_RATE_NONE;
			sample_valid <= pair_ev & (state == SAI_PLAY);
			if (pair_ev && state == SAI_PLAY) begin
				sample_left  <= left_hold;
				sample_right <= right_hold;
			end
		end
	end
endmodule : sai_port

/* File: sai_port_asserts.sv */
// Purpose: Concurrent checks on the serial audio port pins.
// Assumes: Sees only the ports of sai_port.
// Notes:   The idle counter rebuilds the halt time-out from outside the block.
`timescale 1ns/10ps
module sai_port_asserts
	import sai_pkg::*;
#(
	parameter int HALT_CYCLES    = 1000,
	parameter int RECOVER_FRAMES = 2
)(
	input wire logic         clk_sys,
	input wire logic         rst_b,
	input wire logic         clk_bit,
	input wire logic         word_select_frame_sync,
	input wire logic         serial_data_input,
	input wire logic [7:0]   reg_addr,
	input wire logic [7:0]   reg_wdata,
	input wire logic         reg_write,
	input wire logic         reg_read,
	input wire logic [7:0]   reg_rdata,
	input wire logic [31:0]  sample_left,
	input wire logic [31:0]  sample_right,
	input wire logic         sample_valid,
	input wire logic         out_hiz,
	input wire logic         dsp_sleep,
	input wire sai_rate_type proc_clock_rate
);
	// ----------------------------------------------------------------
	// Idle counter and checks
	// ----------------------------------------------------------------
	// The margin of 8 covers the synchroniser and the output register.
	int   idle_cnt;
	logic bit_q;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			idle_cnt <= 0;
			bit_q    <= 1'b0;
		end else begin
			bit_q    <= clk_bit;
			idle_cnt <= (clk_bit != bit_q) ? 0 : (idle_cnt < 100000) ? idle_cnt + 1 : idle_cnt;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence s_wake;
		out_hiz ##1 !out_hiz;
	endsequence
	sequence s_stat_rd;
		reg_read && reg_addr == 8'h71;
	endsequence
	hiz_sleep_a: assert property (out_hiz == dsp_sleep) else $error("hiz and sleep differ");
	sleep_rate_a: assert property (dsp_sleep |-> proc_clock_rate == SAI_RATE_NONE) else $error("rate while asleep");
	awake_rate_a: assert property (!dsp_sleep |-> proc_clock_rate != SAI_RATE_NONE) else $error("awake no rate");
	valid_pulse_a: assert property (sample_valid |=> !sample_valid) else $error("valid too long");
	valid_awake_a: assert property (sample_valid |-> !out_hiz) else $error("sample while hiz");
	rdata_hold_a: assert property (!$past(reg_read) |-> $stable(reg_rdata)) else $error("rdata moved");
	unmapped_rd_a: assert property (reg_read && !(reg_addr inside {8'h33, 8'h34, 8'h71}) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	halt_hiz_a: assert property (idle_cnt == HALT_CYCLES + 8 |-> out_hiz) else $error("no hiz on halt");
	halt_status_a: assert property (s_stat_rd ##0 idle_cnt > HALT_CYCLES + 8 |=> reg_rdata[1:0] == 2'b11)
		else $error("halt not flagged");
	wake_clock_a: assert property (s_wake |-> idle_cnt < 8) else $error("woke without clock");
endmodule : sai_port_asserts

bind sai_port sai_port_asserts #(.HALT_CYCLES(HALT_CYCLES), .RECOVER_FRAMES(RECOVER_FRAMES)) u_chk (
	.clk_sys(clk_sys), .rst_b(rst_b), .clk_bit(clk_bit), .word_select_frame_sync(word_select_frame_sync),
	.serial_data_input(serial_data_input), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.reg_read(reg_read), .reg_rdata(reg_rdata), .sample_left(sample_left), .sample_right(sample_right),
	.sample_valid(sample_valid), .out_hiz(out_hiz), .dsp_sleep(dsp_sleep), .proc_clock_rate(proc_clock_rate));

/* File: sai_sync.sv */
// Purpose: Two-flop synchroniser for levels and toggles.
// Assumes: Each bit is a level or a toggle; multi-bit values are quasi-static.
// Notes:   The first stage feeds only the second.
`timescale 1ns/10ps
module sai_sync #(
	parameter int WIDTH = 1
)(
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("sai_sync: WIDTH must be at least 1.");
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage1 <= '0;
			dout   <= '0;
		end else begin
			stage1 <= din;
			dout   <= stage1;
		end
	end
endmodule : sai_sync

/* File: test_serial_audio_input_port.sv */
// Purpose: Self-checking bench for the serial audio input port.
// Assumes: Default halt time-out; link clock of 125 ns.
// Notes:   Settings change only while the host holds the clocks halted.
`timescale 1ns/10ps
module test_serial_audio_input_port;
	import sai_pkg::*;
	// ----------------------------------------------------------------
	// Stimulus and tasks
	// ----------------------------------------------------------------
	logic         clk_sys = 1'b0, rst_b = 1'b0, reg_write = 1'b0, reg_read = 1'b0, run = 1'b1, ofs = 1'b0;
	logic [7:0]   reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [9:0]   bpf = 10'd64;
	logic [5:0]   wlen = 6'd24;
	logic [31:0]  hl = 32'h0, hr = 32'h0, sample_left, sample_right;
	logic         clk_bit, ws, sd, sample_valid, out_hiz, dsp_sleep;
	sai_fmt_type  fmt = SAI_FMT_I2S;
	sai_rate_type proc_clock_rate;
	int           n_mismatch = 0, checked = 0;
	sai_port u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_bit(clk_bit), .word_select_frame_sync(ws),
		.serial_data_input(sd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .sample_left(sample_left), .sample_right(sample_right),
		.sample_valid(sample_valid), .out_hiz(out_hiz), .dsp_sleep(dsp_sleep), .proc_clock_rate(proc_clock_rate));
	sai_host_model u_host (.run(run), .fmt(fmt), .ofs(ofs), .bpf(bpf), .wlen(wlen), .hl(hl), .hr(hr),
		.clk_bit(clk_bit), .ws(ws), .sd(sd));
	always #20 clk_sys = ~clk_sys;
	task report_and_stop;
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask : rd
	// Waiting 128 us after stopping covers a frame in flight plus the 40 us halt time-out.
	task halt_set(input logic [7:0] f, input logic [7:0] w);
		logic [7:0] d;
		run <= 1'b0;
		repeat (3200) @(posedge clk_sys);
		chk(32'(out_hiz), 32'h1);
		rd(8'h71, d);
		chk(32'(d & 8'h03), 32'h3);
		wr(8'h33, f);
		wr(8'h34, w);
		rd(8'h33, d);
		chk(32'(d), 32'(f));
		rd(8'h34, d);
		chk(32'(d), 32'(w));
	endtask : halt_set
	task wait_valid;
		int k;
		for (k = 0; k < 20000 && sample_valid !== 1'b1; k++) @(negedge clk_sys);
		chk(32'(k < 20000), 32'h1);
		@(negedge clk_sys);
	endtask : wait_valid
	task play(input sai_fmt_type f, input logic [9:0] b, input logic [5:0] wl, input logic [31:0] el,
		input logic [31:0] er, input logic [2:0] rate);
		logic [7:0] d;
		fmt <= f;
		bpf <= b;
		wlen <= wl;
		hl <= el;
		hr <= er;
		run <= 1'b1;
		wait_valid();
		wait_valid();
		chk(sample_left, el);
		chk(sample_right, er);
		chk(32'(proc_clock_rate), 32'(rate));
		rd(8'h71, d);
		chk(32'(d), 32'({1'b0, rate, 4'h0}));
	endtask : play
	task t_regs;
		logic [7:0] d;
		rd(8'h33, d);
		chk(32'(d), 32'h00);
		rd(8'h34, d);
		chk(32'(d), 32'h18);
		wr(8'h55, 8'hff);
		wr(8'h71, 8'hff);
		rd(8'h55, d);
		chk(32'(d), 32'h00);
		rd(8'h33, d);
		chk(32'(d), 32'h00);
		$display("done regs");
	endtask : t_regs
	task t_formats;
		halt_set(8'h00, 8'h18);
		play(SAI_FMT_I2S, 10'd64, 6'd24, 32'h9abcde00, 32'h13579b00, 3'd3);
		halt_set(8'h10, 8'h20);
		play(SAI_FMT_LEFT_JUSTIFIED_FORMAT, 10'd64, 6'd32, 32'hc1a2b3d4, 32'h5e6f7081, 3'd3);
		halt_set(8'h20, 8'h18);
		play(SAI_FMT_RIGHT_JUSTIFIED_FORMAT, 10'd64, 6'd24, 32'h2468ac00, 32'hfedcba00, 3'd3);
		$display("done formats");
	endtask : t_formats
	task t_tdm;
		int o;
		for (o = 0; o < 2; o++) begin
			halt_set(o ? 8'h74 : 8'h34, 8'h10);
			ofs <= o[0];
			play(SAI_FMT_TDM, 10'd128, 6'd16, 32'hbeef0000, 32'h70f10000, 3'd2);
		end
		$display("done tdm");
	endtask : t_tdm
	// A frame rate above every band, then a ratio that TDM does not allow.
	task t_errs;
		logic [7:0] d;
		int         k;
		for (k = 0; k < 2; k++) begin
			halt_set(k ? 8'h30 : 8'h10, k ? 8'h10 : 8'h20);
			fmt <= k ? SAI_FMT_TDM : SAI_FMT_LEFT_JUSTIFIED_FORMAT;
			bpf <= k ? 10'd64 : 10'd32;
			run <= 1'b1;
			repeat (3000) @(posedge clk_sys);
			chk(32'(out_hiz), 32'h1);
			rd(8'h71, d);
			chk(32'(d & 8'h0d), k ? 32'h05 : 32'h09);
		end
		$display("done errors");
	endtask : t_errs
	initial begin
		repeat (4) @(posedge clk_bit);
		@(posedge clk_sys);
		rst_b <= 1'b1;
		t_regs();
		t_formats();
		t_tdm();
		t_errs();
		report_and_stop();
	end
	initial begin
		// About 60,000 system clocks: well past the longest clean run, far below the cycle budget.
		#2400000;
		n_mismatch++;
		report_and_stop();
	end
endmodule : test_serial_audio_input_port
